/* verilog/crlsu_master.sv */
// cached master end: issues coherent reads and applies the answer to one line
// assumes the interconnect end on the same clock; snoop and store come from
// the cache controller on this clock as well
`timescale 1ns/1ps

module crlsu_master
	import crlsu_pkg::*;
(
	// link
	crlsu_if.master lnk,
	// configuration
	input wire logic cfg_snoop_filter,
	// read request from the cache controller
	input wire logic req_valid,
	input wire crlsu_op_e req_op,
	input wire logic req_shareable,
	output logic req_ready,
	output logic req_refused,
	// optional choice of a legal end state other than the expected one
	input wire logic alt_en,
	input wire crlsu_line_e alt_state,
	// snoop effect and local store on the same line
	input wire logic snoop_valid,
	input wire crlsu_line_e snoop_state,
	input wire logic store_valid,
	// line state and completion
	output crlsu_line_e line_state,
	output logic done,
	output logic proto_err
);

	typedef enum logic [1:0] {
		CRLSU_M_IDLE = 2'b00,
		CRLSU_M_ADDR = 2'b01,
		CRLSU_M_WAIT = 2'b10
	} crlsu_m_e;

	crlsu_m_e state_reg;
	crlsu_op_e op_reg;
	crlsu_line_e line_reg;
	crlsu_line_e line_next;
	crlsu_line_e start_st;
	crlsu_line_e exp_st;
	crlsu_mask_t legal_mask;
	logic listed;
	logic start_ok;
	logic rsp_shared;
	logic rsp_dirty;
	logic rsp_take;
	logic done_reg;
	logic err_reg;
	logic refused_reg;

	////////////////////////////////////////////////////////////////////////////
	// link handshakes

	assign req_ready = (state_reg == CRLSU_M_IDLE);
	assign lnk.ar_valid = (state_reg == CRLSU_M_ADDR);
	assign lnk.ar_op = op_reg;
	assign lnk.r_ready = (state_reg == CRLSU_M_WAIT);
	assign rsp_take = lnk.r_valid && (state_reg == CRLSU_M_WAIT);
	assign rsp_shared = lnk.r_resp[`CRLSU_RESP_SHARED_BIT];
	assign rsp_dirty = lnk.r_resp[`CRLSU_RESP_DIRTY_BIT];

	assign line_state = line_reg;
	assign done = done_reg;
	assign proto_err = err_reg;
	assign req_refused = refused_reg;

	// a snoop landing in the response cycle is folded in before the answer
	assign start_st = snoop_valid ? snoop_state : line_reg;

	// every one of the five states has rows for all three reads, so only an
	// undefined code or a non-shareable request is refused
	always_comb begin
		case (line_reg)
			CRLSU_I, CRLSU_UC, CRLSU_UD, CRLSU_SC, CRLSU_SD: start_ok = 1'b1;
			default: start_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// transition table

	always_comb begin
		listed = 1'b0;
		exp_st = start_st;
		case ({rsp_shared, rsp_dirty})
			2'b00: begin
				// clean unique: dirty lines stay dirty, clean ones become UC
				listed = 1'b1;
				if (start_st == CRLSU_UD || start_st == CRLSU_SD) begin
					exp_st = CRLSU_UD;
				end else begin
					exp_st = CRLSU_UC;
				end
			end
			2'b01: begin
				// dirty handed over is only listed from I or SC
				listed = (start_st == CRLSU_I || start_st == CRLSU_SC);
				exp_st = CRLSU_UD;
			end
			2'b10: begin
				// a shared answer is not legal for a unique read
				listed = (op_reg != CRLSU_RD_UNQ) && (start_st == CRLSU_I
					|| start_st == CRLSU_SC || start_st == CRLSU_SD);
				exp_st = (start_st == CRLSU_SD) ? CRLSU_SD : CRLSU_SC;
			end
			2'b11: begin
				// shared dirty only for the shared read, from I or SC
				listed = (op_reg == CRLSU_RD_SHR)
					&& (start_st == CRLSU_I || start_st == CRLSU_SC);
				exp_st = CRLSU_SD;
			end
			default: begin
				listed = 1'b0;
			end
		endcase
		if (!start_ok) begin
			listed = 1'b0;
		end
	end

	// legal end states follow the expected state alone; without a snoop
	// filter a clean line may also be dropped to invalid
	always_comb begin
		legal_mask = '0;
		case (exp_st)
			CRLSU_UC: begin
				legal_mask[CRLSU_UC] = 1'b1;
				legal_mask[CRLSU_SC] = 1'b1;
				legal_mask[CRLSU_I] = !cfg_snoop_filter;
			end
			CRLSU_UD: begin
				legal_mask[CRLSU_UD] = 1'b1;
				legal_mask[CRLSU_SD] = 1'b1;
			end
			CRLSU_SC: begin
				legal_mask[CRLSU_SC] = 1'b1;
				legal_mask[CRLSU_I] = !cfg_snoop_filter;
			end
			CRLSU_SD: begin
				legal_mask[CRLSU_SD] = 1'b1;
			end
			default: begin
				legal_mask = '0;
			end
		endcase
	end

	// an unlisted answer leaves the line at its start state
	always_comb begin
		line_next = start_st;
		if (listed) begin
			line_next = exp_st;
			if (alt_en && legal_mask[alt_state]) begin
				line_next = alt_state;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request sequencer

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			state_reg <= CRLSU_M_IDLE;
		end else begin
			case (state_reg)
				CRLSU_M_IDLE: begin
					if (req_valid && req_shareable && start_ok) begin
						state_reg <= CRLSU_M_ADDR;
					end
				end
				CRLSU_M_ADDR: begin
					if (lnk.ar_ready) begin
						state_reg <= CRLSU_M_WAIT;
					end
				end
				CRLSU_M_WAIT: begin
					if (lnk.r_valid) begin
						state_reg <= CRLSU_M_IDLE;
					end
				end
				default: begin
					state_reg <= CRLSU_M_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			op_reg <= CRLSU_RD_NSD;
		end else if (state_reg == CRLSU_M_IDLE && req_valid) begin
			op_reg <= req_op;
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			refused_reg <= 1'b0;
		end else begin
			refused_reg <= (state_reg == CRLSU_M_IDLE) && req_valid
				&& !(req_shareable && start_ok);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// line state

	// a store only promotes a unique line and is kept apart from the read
	// completion, so it is taken in idle alone
	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			line_reg <= crlsu_line_e'(`CRLSU_ST_RESET);
		end else if (rsp_take) begin
			line_reg <= line_next;
		end else if (snoop_valid) begin
			line_reg <= snoop_state;
		end else if (store_valid && state_reg == CRLSU_M_IDLE
			&& (line_reg == CRLSU_UC || line_reg == CRLSU_UD)) begin
			line_reg <= CRLSU_UD;
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			done_reg <= rsp_take;
			err_reg <= rsp_take && !listed;
		end
	end

endmodule : crlsu_master

/* pkg/crlsu_cfg.svh */
// constants for the coherent read line state update block
// assumes inclusion by the package and both ends of the link
`ifndef CRLSU_CFG_SVH
`define CRLSU_CFG_SVH

// read response field: bit 3 shared, bit 2 dirty handed over
`define CRLSU_RESP_W 4
`define CRLSU_RESP_SHARED_BIT 3
`define CRLSU_RESP_DIRTY_BIT 2
`define CRLSU_RESP_LOW_VALUE 2'h0

// transaction codes on the request channel
`define CRLSU_OP_W 2
`define CRLSU_OP_NSD 2'h0
`define CRLSU_OP_SHR 2'h1
`define CRLSU_OP_UNQ 2'h2

// line state codes and width of a legal end state mask
`define CRLSU_ST_W 3
`define CRLSU_ST_RESET 3'h0
`define CRLSU_MASK_W 5

`endif

/* pkg/crlsu_pkg.sv */
// types shared by both ends of the coherent read link
// assumes crlsu_cfg.svh is on the include path
`include "crlsu_cfg.svh"

package crlsu_pkg;

	// five line states, code doubles as legal mask index
	typedef enum logic [`CRLSU_ST_W-1:0] {
		CRLSU_I = 3'b000,
		CRLSU_UC = 3'b001,
		CRLSU_UD = 3'b010,
		CRLSU_SC = 3'b011,
		CRLSU_SD = 3'b100
	} crlsu_line_e;

	typedef enum logic [`CRLSU_OP_W-1:0] {
		CRLSU_RD_NSD = 2'b00,
		CRLSU_RD_SHR = 2'b01,
		CRLSU_RD_UNQ = 2'b10
	} crlsu_op_e;

	typedef logic [`CRLSU_RESP_W-1:0] crlsu_resp_t;
	typedef logic [`CRLSU_MASK_W-1:0] crlsu_mask_t;

endpackage : crlsu_pkg

/* pkg/crlsu_if.sv */
// request and read response channel between cached master and interconnect
// assumes one clock shared by both ends; the testbench instantiates it
`timescale 1ns/1ps

interface crlsu_if (
	input wire logic ref_clk,
	input wire logic reset
);
	import crlsu_pkg::*;

	logic ar_valid;
	logic ar_ready;
	crlsu_op_e ar_op;
	logic r_valid;
	logic r_ready;
	crlsu_resp_t r_resp;

	modport master (
		input ref_clk,
		input reset,
		output ar_valid,
		input ar_ready,
		output ar_op,
		input r_valid,
		output r_ready,
		input r_resp
	);

	modport icn (
		input ref_clk,
		input reset,
		input ar_valid,
		output ar_ready,
		input ar_op,
		output r_valid,
		input r_ready,
		output r_resp
	);

endinterface : crlsu_if

/* verilog/crlsu_interconnect.sv */
// interconnect end: takes one coherent read, answers with user supplied bits
// assumes the user drives the shared and dirty choice once a read is pending
`timescale 1ns/1ps

module crlsu_interconnect
	import crlsu_pkg::*;
(
	// link
	crlsu_if.icn lnk,
	// user side
	output logic pend_valid,
	output crlsu_op_e pend_op,
	input wire logic rsp_valid,
	input wire logic rsp_shared,
	input wire logic rsp_dirty
);

	typedef enum logic [1:0] {
		CRLSU_IC_IDLE = 2'b00,
		CRLSU_IC_PEND = 2'b01,
		CRLSU_IC_RESP = 2'b10
	} crlsu_ic_e;

	crlsu_ic_e state_reg;
	crlsu_op_e op_reg;
	crlsu_resp_t resp_reg;
	logic shared_next;
	logic dirty_next;

	////////////////////////////////////////////////////////////////////////////

	assign lnk.ar_ready = (state_reg == CRLSU_IC_IDLE);
	assign lnk.r_valid = (state_reg == CRLSU_IC_RESP);
	assign lnk.r_resp = resp_reg;
	assign pend_valid = (state_reg == CRLSU_IC_PEND);
	assign pend_op = op_reg;

	// unique read never reports shared; a shared answer is never dirty
	// for the not-shared-dirty read; the shared read passes all four
	always_comb begin
		shared_next = rsp_shared;
		dirty_next = rsp_dirty;
		if (op_reg == CRLSU_RD_UNQ) begin
			shared_next = 1'b0;
		end
		if (op_reg == CRLSU_RD_NSD && rsp_shared) begin
			dirty_next = 1'b0;
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			state_reg <= CRLSU_IC_IDLE;
		end else begin
			case (state_reg)
				CRLSU_IC_IDLE: begin
					if (lnk.ar_valid) begin
						state_reg <= CRLSU_IC_PEND;
					end
				end
				CRLSU_IC_PEND: begin
					if (rsp_valid) begin
						state_reg <= CRLSU_IC_RESP;
					end
				end
				CRLSU_IC_RESP: begin
					if (lnk.r_ready) begin
						state_reg <= CRLSU_IC_IDLE;
					end
				end
				default: begin
					state_reg <= CRLSU_IC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			op_reg <= CRLSU_RD_NSD;
		end else if (state_reg == CRLSU_IC_IDLE && lnk.ar_valid) begin
			op_reg <= lnk.ar_op;
		end
	end

	always_ff @(posedge lnk.ref_clk) begin
		if (lnk.reset) begin
			resp_reg <= '0;
		end else if (state_reg == CRLSU_IC_PEND && rsp_valid) begin
			resp_reg <= {shared_next, dirty_next, `CRLSU_RESP_LOW_VALUE};
		end
	end

endmodule : crlsu_interconnect

/* verif/crlsu_sva.sv */
// link checker for the coherent read line state update block
// assumes plain inputs wired to the link interface inside the testbench
`timescale 1ns/1ps

module crlsu_sva
	import crlsu_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// request channel
	input wire logic ar_valid,
	input wire logic ar_ready,
	input wire crlsu_op_e ar_op,
	// response channel
	input wire logic r_valid,
	input wire logic r_ready,
	input wire crlsu_resp_t r_resp
);
	crlsu_op_e op_reg;
	logic open_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// op of the read in flight, needed to judge the answer
	always_ff @(posedge ref_clk) begin
		if (reset)
			op_reg <= CRLSU_RD_NSD;
		else if (ar_valid && ar_ready)
			op_reg <= ar_op;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			open_reg <= 1'h0;
		else if (ar_valid && ar_ready)
			open_reg <= 1'h1;
		else if (r_valid && r_ready)
			open_reg <= 1'h0;
	end

	////////////////////////////////////////////////////////////
	ar_hold_a: assert property (ar_valid && !ar_ready |=> ar_valid && $stable(ar_op))
		else $error("read request dropped before taken");
	r_hold_a: assert property (r_valid && !r_ready |=> r_valid && $stable(r_resp))
		else $error("answer changed before taken");
	resp_low_a: assert property (r_valid |-> r_resp[1:0] == 2'h0)
		else $error("answer low bits not zero");
	nsd_clean_a: assert property (r_valid && op_reg == CRLSU_RD_NSD |-> !(r_resp[3] && r_resp[2]))
		else $error("not shared dirty read answered shared dirty");
	unq_only_a: assert property (r_valid && op_reg == CRLSU_RD_UNQ |-> !r_resp[3])
		else $error("unique read answered shared");
	accept_all_a: assert property (r_valid |-> r_ready)
		else $error("master not ready for answer");
	answer_order_a: assert property (r_valid |-> open_reg)
		else $error("answer without read");
	one_open_a: assert property (open_reg |-> !ar_ready ##1 !(ar_valid && ar_ready))
		else $error("second read taken while one is open");
	after_done_a: assert property (r_valid && r_ready |=> !ar_valid && !r_valid)
		else $error("link busy in the cycle after the answer");

	cover property (r_valid && r_ready && op_reg == CRLSU_RD_NSD);
	cover property (r_valid && op_reg == CRLSU_RD_SHR && r_resp[3:2] == 2'h3);
	cover property (r_valid && op_reg == CRLSU_RD_UNQ && r_resp[2]);
endmodule : crlsu_sva

/* verif/crlsu_test.sv */
// testbench joining the cached master end and the interconnect end
// assumes one 50 MHz clock; line states are forced through the snoop port
`timescale 1ns/1ps

module crlsu_test;
	import crlsu_pkg::*;

	logic ref_clk, reset, cfg_snoop_filter, req_valid, req_shareable, alt_en;
	logic snoop_valid, store_valid, rsp_valid, rsp_shared, rsp_dirty;
	// 1: snoop while the read is open, 2: snoop in the answer cycle
	logic [1:0] mid;
	logic req_ready, req_refused, done, proto_err, pend_valid;
	crlsu_op_e req_op, pend_op;
	crlsu_line_e alt_state, snoop_state, line_state;
	int n_mismatch = 0;
	int tests_run = 0;

	crlsu_if crlsu_if_i (.ref_clk(ref_clk), .reset(reset));
	crlsu_master crlsu_master_i (.lnk(crlsu_if_i), .cfg_snoop_filter(cfg_snoop_filter),
		.req_valid(req_valid), .req_op(req_op), .req_shareable(req_shareable),
		.req_ready(req_ready), .req_refused(req_refused), .alt_en(alt_en),
		.alt_state(alt_state), .snoop_valid(snoop_valid), .snoop_state(snoop_state),
		.store_valid(store_valid), .line_state(line_state), .done(done),
		.proto_err(proto_err));
	crlsu_interconnect crlsu_interconnect_i (.lnk(crlsu_if_i), .pend_valid(pend_valid),
		.pend_op(pend_op), .rsp_valid(rsp_valid), .rsp_shared(rsp_shared),
		.rsp_dirty(rsp_dirty));
	crlsu_sva crlsu_sva_i (.ref_clk(ref_clk), .reset(reset),
		.ar_valid(crlsu_if_i.ar_valid), .ar_ready(crlsu_if_i.ar_ready),
		.ar_op(crlsu_if_i.ar_op), .r_valid(crlsu_if_i.r_valid),
		.r_ready(crlsu_if_i.r_ready), .r_resp(crlsu_if_i.r_resp));

	////////////////////////////////////////////////////////////
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask : step

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic complete_run();
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// one read from a forced start state; mid adds a snoop while it is open
	task automatic rd(input crlsu_op_e op, input crlsu_line_e st, input logic [1:0] rs,
		input crlsu_line_e ex, input logic er);
		int n;
		n = 0;
		snoop_state = st;
		snoop_valid = 1'h1;
		step();
		snoop_valid = 1'h0;
		req_op = op;
		req_valid = 1'h1;
		step();
		req_valid = 1'h0;
		while (pend_valid !== 1'h1 && n < 50) begin
			step();
			n++;
		end
		chk(pend_valid, 1'h1);
		chk(pend_op, op);
		if (mid == 2'h1) begin
			snoop_state = CRLSU_SD;
			snoop_valid = 1'h1;
			step();
			snoop_valid = 1'h0;
		end
		{rsp_shared, rsp_dirty} = rs;
		rsp_valid = 1'h1;
		step();
		rsp_valid = 1'h0;
		if (mid == 2'h2) begin
			snoop_state = CRLSU_SD;
			snoop_valid = 1'h1;
		end
		while (done !== 1'h1 && n < 100) begin
			step();
			snoop_valid = 1'h0;
			n++;
		end
		chk(done, 1'h1);
		chk(line_state, ex);
		chk(proto_err, er);
		step();
	endtask : rd

	task automatic refuse();
		req_shareable = 1'h0;
		req_valid = 1'h1;
		step();
		req_valid = 1'h0;
		req_shareable = 1'h1;
		chk(req_refused, 1'h1);
		chk(req_ready, 1'h1);
		chk(crlsu_if_i.ar_valid, 1'h0);
		step();
		chk(req_refused, 1'h0);
	endtask : refuse

	task automatic store_and_reset();
		rd(CRLSU_RD_UNQ, CRLSU_I, 2'h0, CRLSU_UC, 1'h0);
		store_valid = 1'h1;
		step();
		store_valid = 1'h0;
		chk(line_state, CRLSU_UD);
		reset = 1'h1;
		step();
		reset = 1'h0;
		chk(line_state, CRLSU_I);
	endtask : store_and_reset

	task automatic alt_choice();
		alt_en = 1'h1;
		alt_state = CRLSU_I;
		rd(CRLSU_RD_NSD, CRLSU_I, 2'h0, CRLSU_UC, 1'h0);
		cfg_snoop_filter = 1'h0;
		rd(CRLSU_RD_NSD, CRLSU_I, 2'h0, CRLSU_I, 1'h0);
		alt_state = CRLSU_SD;
		rd(CRLSU_RD_UNQ, CRLSU_I, 2'h1, CRLSU_SD, 1'h0);
		cfg_snoop_filter = 1'h1;
		alt_en = 1'h0;
	endtask : alt_choice

	////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial begin
		#40000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		{reset, cfg_snoop_filter, req_shareable} = 3'h7;
		{req_valid, alt_en, snoop_valid, store_valid, rsp_valid, mid} = 7'h0;
		{rsp_shared, rsp_dirty} = 2'h0;
		req_op = CRLSU_RD_NSD;
		alt_state = CRLSU_I;
		snoop_state = CRLSU_I;
		repeat (2) @(posedge ref_clk);
		#1 reset = 1'h0;
		chk(line_state, CRLSU_I);
		rd(CRLSU_RD_NSD, CRLSU_I, 2'h0, CRLSU_UC, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_I, 2'h1, CRLSU_UD, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_I, 2'h2, CRLSU_SC, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_I, 2'h3, CRLSU_SC, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_UD, 2'h0, CRLSU_UD, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_UC, 2'h0, CRLSU_UC, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_SC, 2'h1, CRLSU_UD, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_SD, 2'h0, CRLSU_UD, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_SD, 2'h2, CRLSU_SD, 1'h0);
		rd(CRLSU_RD_NSD, CRLSU_UC, 2'h1, CRLSU_UC, 1'h1);
		rd(CRLSU_RD_SHR, CRLSU_I, 2'h3, CRLSU_SD, 1'h0);
		rd(CRLSU_RD_SHR, CRLSU_SC, 2'h3, CRLSU_SD, 1'h0);
		rd(CRLSU_RD_SHR, CRLSU_SC, 2'h2, CRLSU_SC, 1'h0);
		rd(CRLSU_RD_SHR, CRLSU_UC, 2'h0, CRLSU_UC, 1'h0);
		rd(CRLSU_RD_SHR, CRLSU_UD, 2'h2, CRLSU_UD, 1'h1);
		rd(CRLSU_RD_UNQ, CRLSU_SC, 2'h0, CRLSU_UC, 1'h0);
		rd(CRLSU_RD_UNQ, CRLSU_SD, 2'h0, CRLSU_UD, 1'h0);
		rd(CRLSU_RD_UNQ, CRLSU_SC, 2'h1, CRLSU_UD, 1'h0);
		rd(CRLSU_RD_UNQ, CRLSU_I, 2'h3, CRLSU_UD, 1'h0);
		mid = 2'h1;
		rd(CRLSU_RD_SHR, CRLSU_I, 2'h0, CRLSU_UD, 1'h0);
		mid = 2'h2;
		rd(CRLSU_RD_SHR, CRLSU_I, 2'h0, CRLSU_UD, 1'h0);
		mid = 2'h0;
		alt_choice();
		refuse();
		store_and_reset();
		complete_run();
	end
endmodule : crlsu_test
